/* File: lhp_port.sv */
// Host port: DMA FIFO bus, command/status bus, interrupt, discard
//
// Functional notes
// - Transmit request high while transmit FIFO not full
// - Transmit request drops when FIFO fills, ending burst
// - Receive request high while receive FIFO holds data
// - Receive request drops when receive FIFO empties
// - Byte FIFO bus driven only on receive reads
// - Separate command/status bus, three address inputs
// - Command write: select and write both low
// - Status read: select and read low, drive byte
// - Interrupt high on any enabled condition
// - Each interrupt condition has its own enable
// - Status read clears interrupt automatically
// - End-of-frame line follows direction, marks last byte
// - Discard output high after bad frame or fragment
// - Sixteen consecutive collisions can raise interrupt
`timescale 1ns/1ns
module lhp_port
  import lhp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] fifo_data_bus_in,
  output logic      [7:0] fifo_data_bus_out,
  output logic            fifo_data_bus_oe,
  input  wire logic       tx_channel_ack,
  input  wire logic       rx_channel_ack,
  input  wire logic       tx_fifo_write_n,
  input  wire logic       rx_fifo_read_n,
  output logic            tx_space_request,
  output logic            rx_data_request,
  input  wire logic       transfer_done_n_in,
  output logic            transfer_done_n_out,
  output logic            transfer_done_n_oe,
  input  wire logic [7:0] cmd_status_bus_in,
  output logic      [7:0] cmd_status_bus_out,
  output logic            cmd_status_bus_oe,
  input  wire logic [2:0] addr,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic            irq,
  output logic            rx_discard,
  output logic      [7:0] tx_byte,
  output logic            tx_byte_last,
  output logic            tx_byte_valid,
  input  wire logic       tx_byte_ready,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_byte_last,
  input  wire logic       rx_byte_valid,
  output logic            rx_byte_ready,
  input  wire logic       tx_frame_sent,
  input  wire logic       rx_frame_ok,
  input  wire logic       tx_coll16,
  input  wire logic       rx_bad_frame
);
  // Strobe tracking
  logic             tx_wr_act;   // Transmit write strobe qualified by ack
  logic             tx_wr_act_q; // Previous cycle
  logic             tx_take;     // First cycle of a transmit write
  logic             rx_rd_act;   // Receive read strobe qualified by ack
  logic             rx_rd_act_q; // Previous cycle
  logic             rx_end;      // End of a receive read
  logic             cw_act_q;    // Command write strobe seen in the previous cycle
  logic             cw_take;     // First cycle of a command write
  logic             sr_act;      // Status read in progress
  logic             sr_act_q;    // Previous cycle
  logic             sr_end;      // End of a status read
  // Transmit FIFO
  logic [PTR_W-1:0] tx_wp_q;     // Write pointer
  logic [PTR_W-1:0] tx_rp_q;     // Read pointer
  logic [CNT_W-1:0] tx_cnt_q;    // Fill count
  logic             tx_push;     // Byte enters
  logic             tx_pop;      // Byte leaves to link
  logic [ENTRY_W-1:0] tx_head;   // Head entry
  // Receive FIFO
  logic [PTR_W-1:0] rx_wp_q;     // Write pointer
  logic [PTR_W-1:0] rx_rp_q;     // Read pointer
  logic [CNT_W-1:0] rx_cnt_q;    // Fill count
  logic             rx_push;     // Byte arrives from link
  logic             rx_pop;      // Byte read by DMA
  logic [ENTRY_W-1:0] rx_head;   // Head entry
  // Registers
  logic [EV_W-1:0]  irq_en_q;    // Interrupt enable mask
  logic [EV_W-1:0]  events_q;    // Sticky event flags
  logic [EV_W-1:0]  ev_set;      // Events raised this cycle
  logic             tx_flush;    // Software flush of transmit FIFO
  logic             rx_flush;    // Software flush of receive FIFO
  logic             rx_clear;    // Receive FIFO cleared
  logic [3:0]       disc_cnt_q;  // Discard pulse length counter
  logic [7:0]       rd_val;      // Addressed status byte

  // Strobe decode; the DMA side gates strobes with its acks
  assign tx_wr_act = tx_channel_ack & ~tx_fifo_write_n;
  assign rx_rd_act = rx_channel_ack & ~rx_fifo_read_n;
  assign tx_take   = tx_wr_act & ~tx_wr_act_q;
  assign rx_end    = rx_rd_act_q & ~rx_rd_act;
  assign cw_take   = ~cs_n & ~wr_n & ~cw_act_q;
  assign sr_act    = ~cs_n & ~rd_n;
  assign sr_end    = sr_act_q & ~sr_act;

  // Strobe history
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_wr_act_q <= 1'b0;
      rx_rd_act_q <= 1'b0;
      cw_act_q    <= 1'b0;
      sr_act_q    <= 1'b0;
    end else begin
      tx_wr_act_q <= tx_wr_act;
      rx_rd_act_q <= rx_rd_act;
      cw_act_q    <= ~cs_n & ~wr_n;
      sr_act_q    <= sr_act;
    end
  end

  // Transmit FIFO control; writes to a full FIFO are dropped
  assign tx_push = tx_take & (tx_cnt_q != FIFO_FULL_CNT);
  assign tx_pop  = tx_byte_valid & tx_byte_ready;
  always_ff @(posedge mclk) begin
    if (rst || tx_flush) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_pop);
    end
  end

  // Transmit storage; end-of-frame sampled with the byte
  lhp_mem u_tx_mem (
    .mclk  (mclk),
    .we    (tx_push),
    .waddr (tx_wp_q),
    .wdata ({~transfer_done_n_in, fifo_data_bus_in}),
    .raddr (tx_pop ? tx_rp_q + 1'b1 : tx_rp_q),
    .rdata (tx_head)
  );

  // Request and link outputs
  assign tx_space_request = (tx_cnt_q != FIFO_FULL_CNT);
  assign tx_byte_valid    = (tx_cnt_q != '0);
  assign tx_byte          = tx_head[7:0];
  assign tx_byte_last     = tx_head[8];

  // Receive FIFO control; bad frames flush held data
  assign rx_byte_ready = (rx_cnt_q != FIFO_FULL_CNT);
  assign rx_push       = rx_byte_valid & rx_byte_ready;
  assign rx_pop        = rx_end & (rx_cnt_q != '0);
  assign rx_clear      = rx_flush | rx_bad_frame;
  always_ff @(posedge mclk) begin
    if (rst || rx_clear) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_q + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  // Receive storage
  lhp_mem u_rx_mem (
    .mclk  (mclk),
    .we    (rx_push),
    .waddr (rx_wp_q),
    .wdata ({rx_byte_last, rx_byte}),
    .raddr (rx_pop ? rx_rp_q + 1'b1 : rx_rp_q),
    .rdata (rx_head)
  );

  // Receive request and FIFO bus drive
  assign rx_data_request   = (rx_cnt_q != '0);
  assign fifo_data_bus_out = rx_head[7:0];
  assign fifo_data_bus_oe  = rx_rd_act;
  // End-of-frame driven low only on the last byte of a receive read
  assign transfer_done_n_out = 1'b0;
  assign transfer_done_n_oe  = rx_rd_act & rx_head[8];

  // Command register writes
  assign tx_flush = cw_take & (addr == ADDR_FIFO) & cmd_status_bus_in[FL_TX];
  assign rx_flush = cw_take & (addr == ADDR_FIFO) & cmd_status_bus_in[FL_RX];
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_en_q <= IRQ_EN_RST;
    end else if (cw_take && (addr == ADDR_IRQ)) begin
      irq_en_q <= cmd_status_bus_in[EV_W-1:0];
    end
  end

  // Sticky events; a new event beats the clear from a status read
  always_comb begin
    ev_set             = '0;
    ev_set[EV_TX_DONE] = tx_frame_sent;
    ev_set[EV_RX_DONE] = rx_frame_ok;
    ev_set[EV_COLL16]  = tx_coll16;
    ev_set[EV_RX_BAD]  = rx_bad_frame;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      events_q <= EVENTS_RST;
    end else if (sr_end) begin
      events_q <= ev_set;
    end else begin
      events_q <= events_q | ev_set;
    end
  end
  assign irq = |(events_q & irq_en_q);

  // Discard pulse after a bad frame or fragment
  always_ff @(posedge mclk) begin
    if (rst) begin
      disc_cnt_q <= '0;
    end else if (rx_bad_frame) begin
      disc_cnt_q <= DISCARD_CYC;
    end else if (disc_cnt_q != '0) begin
      disc_cnt_q <= disc_cnt_q - 1'b1;
    end
  end
  assign rx_discard = (disc_cnt_q != '0);

  // Status byte select; unmapped addresses read zero
  always_comb begin
    unique case (addr)
      ADDR_IRQ:  rd_val = {4'h0, events_q};
      ADDR_FIFO: rd_val = {3'h0, tx_cnt_q == FIFO_FULL_CNT,
                           tx_cnt_q == '0, rx_cnt_q == FIFO_FULL_CNT,
                           rx_cnt_q == '0, rx_discard};
      default:   rd_val = 8'h00;
    endcase
  end

  // Status byte taken on the first read cycle and held through the read
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_status_bus_out <= 8'h00;
    end else if (sr_act && !sr_act_q) begin
      cmd_status_bus_out <= rd_val;
    end
  end
  assign cmd_status_bus_oe = sr_act_q & sr_act;

  // Checks
  sequence s_status_read;
    sr_act ##1 !sr_act;
  endsequence
  a_tx_req_full: assert property (@(posedge mclk) disable iff (rst)
    tx_push && !tx_pop && !tx_flush && tx_cnt_q == FIFO_FULL_CNT - 5'h01
    |=> !tx_space_request)
    else $error("transmit request high while FIFO full");
  a_rx_req_data: assert property (@(posedge mclk) disable iff (rst)
    rx_push && !rx_clear |=> rx_data_request)
    else $error("receive request low after a byte arrived");
  a_tx_push_count: assert property (@(posedge mclk) disable iff (rst)
    tx_push && !tx_pop && !tx_flush |=> tx_cnt_q == $past(tx_cnt_q) + 5'h01)
    else $error("transmit write not counted");
  a_rx_read_pop: assert property (@(posedge mclk) disable iff (rst)
    rx_data_request && rx_rd_act && !rx_clear
    ##1 !rx_rd_act && !rx_push && !rx_clear
    |=> rx_cnt_q == $past(rx_cnt_q) - 5'h01)
    else $error("receive read not counted");
  a_fifo_bus_drive: assert property (@(posedge mclk) disable iff (rst)
    fifo_data_bus_oe |-> rx_channel_ack && !rx_fifo_read_n)
    else $error("FIFO bus driven outside receive read");
  a_irq_clear_read: assert property (@(posedge mclk) disable iff (rst)
    s_status_read ##0 (ev_set == 4'h0) |=> !irq)
    else $error("interrupt not cleared by status read");
  a_coll_irq_raise: assert property (@(posedge mclk) disable iff (rst)
    tx_coll16 && irq_en_q[EV_COLL16] && !cw_take |=> irq)
    else $error("collision event did not interrupt");
  a_discard_pulse: assert property (@(posedge mclk) disable iff (rst)
    rx_bad_frame |=> rx_discard [*8])
    else $error("discard pulse too short");
  a_discard_end: assert property (@(posedge mclk) disable iff (rst)
    rx_bad_frame ##1 !rx_bad_frame [*8] |=> !rx_discard)
    else $error("discard pulse too long");
  a_eof_drive: assert property (@(posedge mclk) disable iff (rst)
    transfer_done_n_oe |-> rx_rd_act && rx_head[8])
    else $error("end-of-frame driven at wrong time");
endmodule

/* File: lhp_pkg.sv */
// Shared constants for the LAN controller DMA host port
package lhp_pkg;
  localparam int         FIFO_DEPTH    = 16;    // Bytes per FIFO
  localparam int         PTR_W         = 4;     // FIFO pointer width
  localparam int         CNT_W         = 5;     // FIFO fill count width
  localparam int         ENTRY_W       = 9;     // Byte plus end-of-frame bit
  localparam logic [4:0] FIFO_FULL_CNT = 5'h10; // Count when a FIFO is full
  // Register addresses on the command/status bus
  localparam logic [2:0] ADDR_IRQ      = 3'h0;  // Enable mask / event flags
  localparam logic [2:0] ADDR_FIFO     = 3'h1;  // Flush command / FIFO state
  // Event bit positions
  localparam int         EV_TX_DONE    = 0;
  localparam int         EV_RX_DONE    = 1;
  localparam int         EV_COLL16     = 2;
  localparam int         EV_RX_BAD     = 3;
  localparam int         EV_W          = 4;
  // Flush command bit positions
  localparam int         FL_TX         = 0;
  localparam int         FL_RX         = 1;
  // Values after reset
  localparam logic [3:0] IRQ_EN_RST    = 4'h0;
  localparam logic [3:0] EVENTS_RST    = 4'h0;
  // Cycles the receive discard output stays high
  localparam logic [3:0] DISCARD_CYC   = 4'h8;
endpackage

/* File: lhp_mem.sv */
// Small FIFO storage with registered, write-first read data
`timescale 1ns/1ns
module lhp_mem
  import lhp_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               we,
  input  wire logic [PTR_W-1:0]   waddr,
  input  wire logic [ENTRY_W-1:0] wdata,
  input  wire logic [PTR_W-1:0]   raddr,
  output logic      [ENTRY_W-1:0] rdata
);
  logic [ENTRY_W-1:0] mem [FIFO_DEPTH]; // Storage array

  // Write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register; a same-address write is passed straight through
  always_ff @(posedge mclk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: lhp_dma.sv */
// DMA controller model facing the FIFO bus of the host port
`timescale 1ns/1ns
module lhp_dma (
  input  wire logic       mclk,
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_data_oe,
  input  wire logic       dev_done_n,
  input  wire logic       dev_done_oe,
  input  wire logic       rx_discard,
  output logic      [7:0] bus_data,
  output logic            bus_done_n,
  output logic            tx_ack,
  output logic            rx_ack,
  output logic            wr_n,
  output logic            rd_n
);
  logic [7:0] drv_q;    // Last byte this model drove
  logic       drv_en;   // High while this model drives the bus
  logic       eof_n;    // End-of-frame level sent with a byte
  int         restarts; // Receive channel restarts seen
  logic       disc_q = 1'b0; // Discard level at the previous edge
  // Undriven bus shows the inverse of the last byte
  assign bus_data = dev_data_oe ? dev_data : (drv_en ? drv_q : ~drv_q);
  // End-of-frame line idles high through its pull-up
  assign bus_done_n = dev_done_oe ? dev_done_n : (drv_en ? eof_n : 1'b1);
  initial begin
    {tx_ack, rx_ack, drv_en} = 3'b000;
    {wr_n, rd_n, eof_n} = 3'b111;
    drv_q = 8'h00;
    restarts = 0;
  end
  // A rising discard restarts the receive channel once, no processor
  always @(posedge mclk) begin
    disc_q <= rx_discard;
    if (rx_discard && !disc_q) begin
      restarts <= restarts + 1;
    end
  end
  // One transmit byte; acknowledge and write strobe move together
  task automatic put(input logic [7:0] d, input logic last);
    @(posedge mclk) #1;
    drv_q = d;
    eof_n = ~last;
    drv_en = 1'b1;
    tx_ack = 1'b1;
    wr_n = 1'b0;
    @(posedge mclk) #1;
    {tx_ack, drv_en} = 2'b00;
    {wr_n, eof_n} = 2'b11;
  endtask
  // One receive byte, taken at the edge before release
  task automatic get(output logic [7:0] d, output logic last);
    @(posedge mclk) #1;
    rx_ack = 1'b1;
    rd_n = 1'b0;
    @(posedge mclk);
    d = bus_data;
    last = ~bus_done_n;
    #1;
    rx_ack = 1'b0;
    rd_n = 1'b1;
    @(posedge mclk) #1;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking testbench for the LAN controller DMA host port
`timescale 1ns/1ns
module testbench;
  import lhp_pkg::*;
  logic       mclk, rst, tx_channel_ack, rx_channel_ack;
  logic       tx_fifo_write_n, rx_fifo_read_n, transfer_done_n_in;
  logic [7:0] fifo_data_bus_in, fifo_data_bus_out, cmd_status_bus_in;
  logic [7:0] cmd_status_bus_out, tx_byte, rx_byte, d;
  logic       fifo_data_bus_oe, tx_space_request, rx_data_request;
  logic       transfer_done_n_out, transfer_done_n_oe, cmd_status_bus_oe;
  logic [2:0] addr;
  logic       cs_n, rd_n, wr_n, irq, rx_discard, tx_byte_last, l;
  logic       tx_byte_valid, tx_byte_ready, rx_byte_last, rx_byte_valid;
  logic       rx_byte_ready, tx_frame_sent, rx_frame_ok, tx_coll16;
  logic       rx_bad_frame;
  int         num_errors, tests_run, k;
  // Device under test
  lhp_port lhp_port_i (.mclk, .rst, .fifo_data_bus_in, .fifo_data_bus_out,
    .fifo_data_bus_oe, .tx_channel_ack, .rx_channel_ack, .tx_fifo_write_n,
    .rx_fifo_read_n, .tx_space_request, .rx_data_request,
    .transfer_done_n_in, .transfer_done_n_out, .transfer_done_n_oe,
    .cmd_status_bus_in, .cmd_status_bus_out, .cmd_status_bus_oe, .addr,
    .cs_n, .rd_n, .wr_n, .irq, .rx_discard, .tx_byte, .tx_byte_last,
    .tx_byte_valid, .tx_byte_ready, .rx_byte, .rx_byte_last,
    .rx_byte_valid, .rx_byte_ready, .tx_frame_sent, .rx_frame_ok,
    .tx_coll16, .rx_bad_frame);
  // DMA side of the FIFO bus
  lhp_dma lhp_dma_i (.mclk, .dev_data(fifo_data_bus_out),
    .dev_data_oe(fifo_data_bus_oe), .dev_done_n(transfer_done_n_out),
    .dev_done_oe(transfer_done_n_oe), .rx_discard,
    .bus_data(fifo_data_bus_in), .bus_done_n(transfer_done_n_in),
    .tx_ack(tx_channel_ack), .rx_ack(rx_channel_ack),
    .wr_n(tx_fifo_write_n), .rd_n(rx_fifo_read_n));
  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Inputs move just after the rising edge
  task automatic step;
    @(posedge mclk) #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One-cycle event pulse on input bit b
  task automatic ev(input int b);
    {rx_bad_frame, tx_coll16, rx_frame_ok, tx_frame_sent} = 4'h1 << b;
    step();
    {rx_bad_frame, tx_coll16, rx_frame_ok, tx_frame_sent} = 4'h0;
  endtask
  task automatic host_write(input logic [2:0] a, input logic [7:0] v);
    addr = a;
    cmd_status_bus_in = v;
    {cs_n, wr_n} = 2'b00;
    step();
    {cs_n, wr_n} = 2'b11;
    cmd_status_bus_in = ~v;
    step();
  endtask
  task automatic host_read(input logic [2:0] a, output logic [7:0] v);
    addr = a;
    {cs_n, rd_n} = 2'b00;
    step();
    step();
    chk("cs_oe", 8'(cmd_status_bus_oe), 8'h01);
    v = cmd_status_bus_out;
    {cs_n, rd_n} = 2'b11;
    step();
    step();
  endtask
  // Fill the transmit FIFO past full, then drain it on the link side
  task automatic t_tx;
    for (int i = 0; i < 17; i++) begin
      lhp_dma_i.put(8'(i), i == 15);
      chk("tx_req", 8'(tx_space_request), 8'(i < 15));
    end
    tx_byte_ready = 1'b1;
    k = 0;
    // Head is judged just after an edge; it leaves at the next edge
    repeat (24) begin
      if (tx_byte_valid === 1'b1) begin
        chk("tx_byte", tx_byte, 8'(k));
        chk("tx_last", 8'(tx_byte_last), 8'(k == 15));
        k++;
      end
      step();
    end
    chk("tx_pops", 8'(k), 8'(FIFO_FULL_CNT));
    chk("tx_req", 8'(tx_space_request), 8'h01);
    tx_byte_ready = 1'b0;
  endtask
  // Three-byte frame read back by the receive channel
  task automatic t_rx;
    for (int i = 0; i < 3; i++) begin
      rx_byte = 8'ha0 + 8'(i);
      rx_byte_last = (i == 2);
      rx_byte_valid = 1'b1;
      step();
    end
    rx_byte_valid = 1'b0;
    step();
    chk("rx_req", 8'(rx_data_request), 8'h01);
    chk("fifo_oe", 8'(fifo_data_bus_oe), 8'h00);
    chk("rx_ready", 8'(rx_byte_ready), 8'h01);
    for (int i = 0; i < 3; i++) begin
      lhp_dma_i.get(d, l);
      chk("rx_data", d, 8'ha0 + 8'(i));
      chk("rx_eof", 8'(l), 8'(i == 2));
      step();
      chk("rx_req", 8'(rx_data_request), 8'(i < 2));
    end
  endtask
  // Masked and enabled events, status read clears the request
  task automatic t_irq;
    host_write(ADDR_IRQ, 8'h04);
    ev(EV_TX_DONE);
    chk("irq", 8'(irq), 8'h00);
    step();
    ev(EV_COLL16);
    chk("irq", 8'(irq), 8'h01);
    host_read(ADDR_IRQ, d);
    chk("events", d, 8'h05);
    chk("irq", 8'(irq), 8'h00);
    host_read(ADDR_FIFO, d);
    chk("fifo_st", d, 8'h0a);
    chk("cs_oe", 8'(cmd_status_bus_oe), 8'h00);
  endtask
  // Bad frame flushes receive data and raises discard for a while
  task automatic t_discard;
    rx_byte_valid = 1'b1;
    step();
    rx_byte_valid = 1'b0;
    ev(EV_RX_BAD);
    k = 0;
    repeat (10) begin
      k += int'(rx_discard === 1'b1);
      step();
    end
    chk("discard", 8'(k), 8'(DISCARD_CYC));
    chk("rx_req", 8'(rx_data_request), 8'h00);
    chk("restart", 8'(lhp_dma_i.restarts), 8'h01);
  endtask
  // Command write flushes both FIFOs
  task automatic t_flush;
    lhp_dma_i.put(8'h5a, 1'b0);
    rx_byte_valid = 1'b1;
    step();
    rx_byte_valid = 1'b0;
    chk("tx_valid", 8'(tx_byte_valid), 8'h01);
    chk("rx_req", 8'(rx_data_request), 8'h01);
    host_write(ADDR_FIFO, 8'h03);
    chk("tx_valid", 8'(tx_byte_valid), 8'h00);
    chk("rx_req", 8'(rx_data_request), 8'h00);
    chk("tx_req", 8'(tx_space_request), 8'h01);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    {cs_n, rd_n, wr_n} = 3'b111;
    addr = 3'h0;
    cmd_status_bus_in = 8'h00;
    {tx_byte_ready, rx_byte_valid, rx_byte_last} = 3'b000;
    rx_byte = 8'h00;
    {rx_bad_frame, tx_coll16, rx_frame_ok, tx_frame_sent} = 4'h0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    chk("tx_req", 8'(tx_space_request), 8'h01);
    chk("rx_req", 8'(rx_data_request), 8'h00);
    chk("irq", 8'(irq), 8'h00);
    t_tx();
    t_rx();
    t_irq();
    t_discard();
    t_flush();
    print_verdict();
  end
  // Watchdog for a hung handshake
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule
